// ---- core/safety_tap_diagnostic_status.sv ----
// status and diagnostic reporting core of one safety tap node, apb slave
`timescale 1ns/1ps
module safety_tap_diagnostic_status
	import tap_diag_pkg::*;
(
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// tap pins
	input  wire logic              demand_pin,
	input  wire logic              chan_a_pin,
	input  wire logic              chan_b_pin,
	input  wire logic              aux_pin,
	input  wire logic              safe_state_pin,
	input  wire logic              internal_err_pin,
	input  wire logic              pin_short_pin,
	input  wire logic              signal_corrupt_pin,
	input  wire logic              supply_low_pin,
	input  wire logic              supply_high_pin,
	// status outputs
	output logic                   link_lost_flag,
	output logic                   diag_present_flag,
	output logic                   node_fault_rollup,
	output logic                   safety_demand_bit
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [NUM_PINS-1:0]  pins;
	logic [NUM_PINS-1:0]  sync1_q;
	logic [NUM_PINS-1:0]  sync2_q;
	logic [CTRL_W-1:0]    ctrl_q;
	logic                 node_rst_q;
	logic                 prod_rst_q;
	link_state_t          link_q;
	link_state_t          link_d;
	logic [31:0]          prdata_q;
	logic                 pready_q;
	logic                 pslverr_q;
	logic                 link_lost_q;
	logic                 diag_present_q;
	logic                 rollup_q;
	logic                 demand_q;
	logic                 setup;
	logic                 wr_access;
	logic                 addr_hit;
	logic [31:0]          rd_data;
	logic [31:0]          status_word;
	logic                 fw2;
	logic                 aux8;
	logic                 awaiting;
	logic                 chan_a_rep;
	logic                 chan_b_rep;
	logic                 aux_rep;
	logic [NUM_FLAGS-1:0] cond;
	logic [NUM_COND-1:0]  diag_vec;

	diag_if #(
		.N (NUM_FLAGS),
		.C (NUM_COND),
		.W (CNT_W)
	) dif ();

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	assign pins = {
		supply_high_pin,
		supply_low_pin,
		signal_corrupt_pin,
		pin_short_pin,
		internal_err_pin,
		safe_state_pin,
		aux_pin,
		chan_b_pin,
		chan_a_pin,
		demand_pin
	};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
		end
	end

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	assign setup     = psel && !penable;
	assign wr_access = psel && penable && pwrite && pready_q;

	always_comb begin
		case (paddr)
			OFF_STATUS: addr_hit = 1'b1;
			OFF_COUNT:  addr_hit = 1'b1;
			OFF_CTRL:   addr_hit = 1'b1;
			OFF_CMD:    addr_hit = 1'b1;
			default:    addr_hit = 1'b0;
		endcase
	end

	always_comb begin
		case (paddr)
			OFF_STATUS: rd_data = status_word;
			OFF_COUNT:  rd_data = {{(32-CNT_W){1'b0}}, dif.count};
			OFF_CTRL:   rd_data = {{(32-CTRL_W){1'b0}}, ctrl_q};
			default:    rd_data = 32'h0000_0000;
		endcase
	end

	// answer lands in the access cycle, one cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup && !addr_hit;
			if (setup && !pwrite) begin
				prdata_q <= rd_data;
			end
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RST;
		end else if (wr_access && paddr == OFF_CTRL && pstrb[0]) begin
			ctrl_q <= pwdata[CTRL_W-1:0];
		end
	end

	assign fw2  = ctrl_q[CTRL_FW2];
	assign aux8 = ctrl_q[CTRL_AUX8];

	// ------------------------------------------------------------
	// command pulses
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			node_rst_q <= 1'b0;
			prod_rst_q <= 1'b0;
		end else begin
			node_rst_q <= wr_access && paddr == OFF_CMD && pstrb[0]
				&& pwdata[CMD_NODE_RST];
			prod_rst_q <= wr_access && paddr == OFF_CMD && pstrb[0]
				&& pwdata[CMD_PROD_RST];
		end
	end

	// ------------------------------------------------------------
	// safety link state
	// ------------------------------------------------------------
	always_comb begin
		link_d = link_q;
		case (link_q)
			ST_WAIT: begin
				if (ctrl_q[CTRL_LINK] && !prod_rst_q) begin
					link_d = ST_UP;
				end
			end
			ST_UP: begin
				if (!ctrl_q[CTRL_LINK] || prod_rst_q) begin
					link_d = ST_WAIT;
				end
			end
			default: link_d = ST_WAIT;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_q <= ST_WAIT;
		end else begin
			link_q <= link_d;
		end
	end

	assign awaiting = (link_q == ST_WAIT);

	// ------------------------------------------------------------
	// diagnostic conditions
	// ------------------------------------------------------------
	always_comb begin
		cond             = '0;
		cond[F_INTERNAL] = sync2_q[P_INTERNAL];
		cond[F_SHORT]    = sync2_q[P_SHORT];
		cond[F_CORRUPT]  = sync2_q[P_CORRUPT];
		cond[F_LOW]      = sync2_q[P_LOW]
			|| (!fw2 && sync2_q[P_HIGH]);
		cond[F_HIGH]     = fw2 && sync2_q[P_HIGH];
		cond[F_MISMATCH] = sync2_q[P_CHAN_A] ^ sync2_q[P_CHAN_B];
	end

	assign dif.cond     = cond;
	assign dif.upd_en   = sync2_q[P_SAFE];
	assign dif.cnt_clr  = prod_rst_q;
	assign diag_vec     = {awaiting, dif.flags};
	assign dif.diag_vec = diag_vec;

	always_comb begin
		dif.clr             = '0;
		dif.clr[F_INTERNAL] = node_rst_q;
	end

	// ------------------------------------------------------------
	// flag bank and sequence counter
	// ------------------------------------------------------------
	flag_bank #(
		.N      (NUM_FLAGS),
		.STICKY (FLAG_STICKY)
	) u_flags (
		.clk   (pclk),
		.rst_n (presetn),
		.b     (dif.bank)
	);

	diag_counter #(
		.C (NUM_COND),
		.W (CNT_W)
	) u_count (
		.clk   (pclk),
		.rst_n (presetn),
		.c     (dif.counter)
	);

	// ------------------------------------------------------------
	// reported channel states
	// ------------------------------------------------------------
	assign chan_a_rep = fw2 && !awaiting && sync2_q[P_CHAN_A];
	assign chan_b_rep = fw2 && !awaiting && sync2_q[P_CHAN_B];
	assign aux_rep    = fw2 && aux8 && sync2_q[P_AUX];

	// ------------------------------------------------------------
	// rollup outputs
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_lost_q    <= 1'b0;
			diag_present_q <= 1'b0;
			rollup_q       <= 1'b0;
			demand_q       <= 1'b0;
		end else begin
			link_lost_q    <= 1'b0;
			diag_present_q <= |diag_vec;
			rollup_q       <= |diag_vec;
			demand_q       <= sync2_q[P_DEMAND];
		end
	end

	assign link_lost_flag    = link_lost_q;
	assign diag_present_flag = diag_present_q;
	assign node_fault_rollup = rollup_q;
	assign safety_demand_bit = demand_q;

	// ------------------------------------------------------------
	// status word
	// ------------------------------------------------------------
	always_comb begin
		status_word                                    = 32'h0000_0000;
		status_word[ST_LINK_LOST]                      = link_lost_q;
		status_word[ST_DIAG]                           = diag_present_q;
		status_word[ST_DEMAND]                         = demand_q;
		status_word[ST_ROLLUP]                         = rollup_q;
		status_word[ST_AUX]                            = aux_rep;
		status_word[ST_CHAN_A]                         = chan_a_rep;
		status_word[ST_CHAN_B]                         = chan_b_rep;
		status_word[ST_FLAG_LSB +: NUM_FLAGS]          = dif.flags;
		status_word[ST_LINK_UP]                        = !awaiting;
	end

endmodule // safety_tap_diagnostic_status

// ---- pkg/tap_diag_pkg.sv ----
// constants, register map and types of the tap diagnostic status block
package tap_diag_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam int unsigned  ADDR_W       = 12;
	localparam logic [11:0]  OFF_STATUS   = 12'h000;
	localparam logic [11:0]  OFF_COUNT    = 12'h004;
	localparam logic [11:0]  OFF_CTRL     = 12'h008;
	localparam logic [11:0]  OFF_CMD      = 12'h00c;

	// ------------------------------------------------------------
	// status register fields
	// ------------------------------------------------------------
	localparam int unsigned  ST_LINK_LOST = 0;
	localparam int unsigned  ST_DIAG      = 1;
	localparam int unsigned  ST_DEMAND    = 2;
	localparam int unsigned  ST_ROLLUP    = 3;
	localparam int unsigned  ST_AUX       = 4;
	localparam int unsigned  ST_CHAN_A    = 5;
	localparam int unsigned  ST_CHAN_B    = 6;
	localparam int unsigned  ST_FLAG_LSB  = 7;
	localparam int unsigned  ST_LINK_UP   = 13;

	// ------------------------------------------------------------
	// control and command fields
	// ------------------------------------------------------------
	localparam int unsigned  CTRL_W        = 3;
	localparam int unsigned  CTRL_FW2      = 0;
	localparam int unsigned  CTRL_AUX8     = 1;
	localparam int unsigned  CTRL_LINK     = 2;
	localparam logic [2:0]   CTRL_RST      = 3'h1;
	localparam int unsigned  CMD_NODE_RST  = 0;
	localparam int unsigned  CMD_PROD_RST  = 1;

	// ------------------------------------------------------------
	// diagnostic flags and conditions
	// ------------------------------------------------------------
	localparam int unsigned  F_INTERNAL   = 0;
	localparam int unsigned  F_SHORT      = 1;
	localparam int unsigned  F_CORRUPT    = 2;
	localparam int unsigned  F_LOW        = 3;
	localparam int unsigned  F_HIGH       = 4;
	localparam int unsigned  F_MISMATCH   = 5;
	localparam int unsigned  NUM_FLAGS    = 6;
	localparam int unsigned  NUM_COND     = 7;
	localparam logic [5:0]   FLAG_STICKY  = 6'h3b;

	// ------------------------------------------------------------
	// tap pin vector
	// ------------------------------------------------------------
	localparam int unsigned  P_DEMAND     = 0;
	localparam int unsigned  P_CHAN_A     = 1;
	localparam int unsigned  P_CHAN_B     = 2;
	localparam int unsigned  P_AUX        = 3;
	localparam int unsigned  P_SAFE       = 4;
	localparam int unsigned  P_INTERNAL   = 5;
	localparam int unsigned  P_SHORT      = 6;
	localparam int unsigned  P_CORRUPT    = 7;
	localparam int unsigned  P_LOW        = 8;
	localparam int unsigned  P_HIGH       = 9;
	localparam int unsigned  NUM_PINS     = 10;

	// ------------------------------------------------------------
	// sequence counter
	// ------------------------------------------------------------
	localparam int unsigned  CNT_W        = 8;
	localparam logic [7:0]   CNT_RST      = 8'h00;

	typedef enum logic {
		ST_WAIT = 1'b0,
		ST_UP   = 1'b1
	} link_state_t;

endpackage

// ---- pkg/diag_if.sv ----
// carrier between the status core, its flag bank and its sequence counter
`timescale 1ns/1ps
interface diag_if #(
	parameter int N = 6,
	parameter int C = 7,
	parameter int W = 8
);
	logic [N-1:0] cond;
	logic [N-1:0] clr;
	logic [N-1:0] flags;
	logic         upd_en;
	logic [C-1:0] diag_vec;
	logic         cnt_clr;
	logic [W-1:0] count;

	modport ctrl (output cond, clr, upd_en, diag_vec, cnt_clr, input flags, count);
	modport bank (input cond, clr, upd_en, output flags);
	modport counter (input diag_vec, cnt_clr, output count);
endinterface

// ---- core/flag_bank.sv ----
// bank of latched or level diagnostic flags
`timescale 1ns/1ps
module flag_bank #(
	parameter int          N      = 6,
	parameter logic [5:0]  STICKY = 6'h3b
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// flag carrier
	diag_if.bank      b
);
	logic [N-1:0] flags_q;

	assign b.flags = flags_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (b.upd_en && b.cond[i]) begin
					flags_q[i] <= 1'b1;
				end else if (STICKY[i]) begin
					if (b.clr[i]) begin
						flags_q[i] <= 1'b0;
					end
				end else if (b.upd_en) begin
					flags_q[i] <= 1'b0;
				end
			end
		end
	end
endmodule // flag_bank

// ---- core/diag_counter.sv ----
// wrapping diagnostic sequence counter
`timescale 1ns/1ps
module diag_counter
	import tap_diag_pkg::*;
#(
	parameter int C = 7,
	parameter int W = 8
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// counter carrier
	diag_if.counter   c
);
	localparam logic [W:0] CNT_MAX = {1'b0, {W{1'b1}}};

	logic [C-1:0] prev_q;
	logic [W-1:0] count_q;
	logic [W-1:0] count_d;
	logic [W:0]   sum;
	logic [W-1:0] n_chg;

	assign c.count = count_q;

	always_comb begin
		n_chg = '0;
		for (int i = 0; i < C; i++) begin
			n_chg = n_chg + W'(c.diag_vec[i] ^ prev_q[i]);
		end
		sum = {1'b0, count_q} + {1'b0, n_chg};
		if (sum > CNT_MAX) begin
			count_d = W'(sum - CNT_MAX);
		end else begin
			count_d = sum[W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_q  <= '0;
			count_q <= W'(CNT_RST);
		end else begin
			prev_q <= c.diag_vec;
			if (c.cnt_clr) begin
				count_q <= W'(CNT_RST);
			end else begin
				count_q <= count_d;
			end
		end
	end
endmodule // diag_counter

// ---- sim/tap_status_sva.sv ----
// assertion checker for the tap diagnostic status block
`timescale 1ns/1ps
module tap_status_sva
	import tap_diag_pkg::*;
(
	// clock and reset
	input wire logic              pclk,
	input wire logic              presetn,
	// apb
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// pins and status
	input wire logic              demand_pin,
	input wire logic              link_lost_flag,
	input wire logic              diag_present_flag,
	input wire logic              node_fault_rollup,
	input wire logic              safety_demand_bit
);
	// cycles since reset release, saturating
	logic [1:0] age_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) age_q <= 2'h0;
		else if (age_q != 2'h3) age_q <= age_q + 2'h1;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		pready;
	endsequence

	a_access_after_setup: assert property (s_setup |=> s_access)
		else $error("no ready in access cycle");
	a_ready_only_access: assert property (pready |-> $past(psel) && !$past(penable))
		else $error("ready outside access cycle");
	a_unmapped_err: assert property ((s_setup and (paddr > OFF_CMD)) |=> pslverr && pready)
		else $error("unmapped address not refused");
	a_mapped_ok: assert property ((s_setup and (paddr[1:0] == 2'h0 && paddr <= OFF_CMD))
		|=> !pslverr)
		else $error("mapped address refused");
	a_cmd_reads_zero: assert property ((s_setup and (!pwrite && paddr == OFF_CMD))
		|=> prdata == 32'h0)
		else $error("command register read not zero");
	a_status_link_bit: assert property ((s_setup and (!pwrite && paddr == OFF_STATUS))
		|=> !prdata[ST_LINK_LOST])
		else $error("status shows link lost");
	a_link_lost_zero: assert property (link_lost_flag == 1'b0)
		else $error("link lost flag driven high");
	a_diag_eq_rollup: assert property (diag_present_flag == node_fault_rollup)
		else $error("diag flag differs from rollup");
	a_fault_after_reset: assert property (!$past(presetn) |=> diag_present_flag && node_fault_rollup)
		else $error("no fault after reset");
	a_demand_delay: assert property (age_q == 2'h3 |-> safety_demand_bit == $past(demand_pin, 3))
		else $error("demand bit does not follow pin");
endmodule // tap_status_sva

bind safety_tap_diagnostic_status tap_status_sva i_sva (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.demand_pin(demand_pin), .link_lost_flag(link_lost_flag),
	.diag_present_flag(diag_present_flag), .node_fault_rollup(node_fault_rollup),
	.safety_demand_bit(safety_demand_bit)
);

// ---- sim/tap_far_side.sv ----
// far side model: tap pin levels and the controller's link copy
`timescale 1ns/1ps
module tap_far_side (
	// clock
	input  wire logic       pclk,
	// requested levels
	input  wire logic [9:0] want,
	input  wire logic       link_faulted,
	input  wire logic       link_lost_flag,
	// driven pins and controller copy
	output logic      [9:0] pins,
	output logic            link_lost_copy
);
	initial pins = 10'h000;
	always @(posedge pclk) pins <= want;
	// controller forces its copy high on a faulted link
	always_comb link_lost_copy = link_faulted | link_lost_flag;
endmodule // tap_far_side

// ---- sim/test_safety_tap_diagnostic_status.sv ----
// self-checking testbench of the tap diagnostic status block
`timescale 1ns/1ps
module test_safety_tap_diagnostic_status
	import tap_diag_pkg::*;
;
	logic              pclk, presetn, psel, penable, pwrite, link_faulted;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic [3:0]        pstrb;
	logic              pready, pslverr, last_err, link_lost_copy;
	logic [9:0]        want, pins;
	logic              link_lost_flag, diag_present_flag, node_fault_rollup, safety_demand_bit;
	logic [7:0]        exp_cnt;
	int                err_total, samples_checked, n;

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	safety_tap_diagnostic_status i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .demand_pin(pins[P_DEMAND]), .chan_a_pin(pins[P_CHAN_A]),
		.chan_b_pin(pins[P_CHAN_B]), .aux_pin(pins[P_AUX]), .safe_state_pin(pins[P_SAFE]),
		.internal_err_pin(pins[P_INTERNAL]), .pin_short_pin(pins[P_SHORT]),
		.signal_corrupt_pin(pins[P_CORRUPT]), .supply_low_pin(pins[P_LOW]),
		.supply_high_pin(pins[P_HIGH]), .link_lost_flag(link_lost_flag),
		.diag_present_flag(diag_present_flag), .node_fault_rollup(node_fault_rollup),
		.safety_demand_bit(safety_demand_bit)
	);
	tap_far_side i_far (
		.pclk(pclk), .want(want), .link_faulted(link_faulted),
		.link_lost_flag(link_lost_flag), .pins(pins), .link_lost_copy(link_lost_copy)
	);

	// ------------------------------------------------------------
	// expectations and checks
	// ------------------------------------------------------------
	function automatic logic [7:0] cnt_add(input logic [7:0] c, input int k);
		for (int i = 0; i < k; i++) c = (c == 8'hff) ? 8'h01 : c + 8'h01;
		return c;
	endfunction
	function automatic logic [31:0] st_word(input logic [5:0] f, input logic d);
		return (32'(f) << ST_FLAG_LSB) | (32'(d) << ST_DIAG) | (32'(d) << ST_ROLLUP);
	endfunction
	function automatic logic [9:0] pb(input int i);
		return 10'h001 << i;
	endfunction
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask
	task automatic st_chk(input logic [5:0] f, input logic d);
		rd_chk(OFF_STATUS, st_word(f, d), 32'h00001f8a);
		chk({29'h0, link_lost_flag, diag_present_flag, node_fault_rollup},
			{29'h0, 1'b0, d, d});
	endtask
	task automatic cnt_chk(input int k);
		exp_cnt = cnt_add(exp_cnt, k);
		rd_chk(OFF_COUNT, {24'h0, exp_cnt}, 32'h000000ff);
	endtask
	task automatic setp(input logic [9:0] m, input logic v);
		@(posedge pclk);
		want <= v ? (want | m) : (want & ~m);
		repeat (8) @(posedge pclk);
	endtask
	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		exp_cnt = 8'h01;
		repeat (2) @(posedge pclk);
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		#200000;
		err_total++;
		end_sim();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hf;
		want = '0;
		link_faulted = 1'b0;
		err_total = 0;
		samples_checked = 0;
		exp_cnt = 8'h00;
		void'($urandom(32'hacc8c57e));
		do_reset();
		cnt_chk(0);
		rd_chk(OFF_STATUS, 32'h0000000a, 32'h00003f8f);
		rd_chk(OFF_CTRL, 32'h1, 32'h7);
		rd_chk(OFF_CMD, 32'h0, 32'hffffffff);
		rd_chk(12'h010, 32'h0, 32'hffffffff);
		chk({31'h0, last_err}, 32'h1);
		apb(1'b1, OFF_CTRL, 32'h5);
		cnt_chk(1);
		st_chk(6'h00, 1'b0);
		pstrb <= 4'h0;
		apb(1'b1, OFF_CTRL, 32'h0);
		pstrb <= 4'hf;
		rd_chk(OFF_CTRL, 32'h5, 32'h7);
		setp(pb(P_DEMAND) | pb(P_CHAN_A) | pb(P_CHAN_B) | pb(P_AUX), 1'b1);
		rd_chk(OFF_STATUS, 32'h64, 32'h74);
		chk({31'h0, safety_demand_bit}, 32'h1);
		apb(1'b1, OFF_CTRL, 32'h7);
		rd_chk(OFF_STATUS, 32'h74, 32'h74);
		apb(1'b1, OFF_CTRL, 32'h6);
		rd_chk(OFF_STATUS, 32'h04, 32'h74);
		apb(1'b1, OFF_CTRL, 32'h5);
		setp(pb(P_DEMAND) | pb(P_CHAN_A) | pb(P_CHAN_B) | pb(P_AUX), 1'b0);
		chk({31'h0, safety_demand_bit}, 32'h0);
		setp(pb(P_SHORT), 1'b1);
		st_chk(6'h00, 1'b0);
		setp(pb(P_SHORT), 1'b0);
		cnt_chk(0);
		setp(pb(P_SAFE), 1'b1);
		setp(pb(P_INTERNAL), 1'b1);
		setp(pb(P_INTERNAL), 1'b0);
		st_chk(6'h01, 1'b1);
		cnt_chk(1);
		apb(1'b1, OFF_CMD, 32'h1);
		st_chk(6'h00, 1'b0);
		cnt_chk(1);
		setp(pb(P_SHORT) | pb(P_LOW), 1'b1);
		setp(pb(P_SHORT) | pb(P_LOW), 1'b0);
		apb(1'b1, OFF_CMD, 32'h1);
		st_chk(6'h0a, 1'b1);
		cnt_chk(2);
		setp(pb(P_CORRUPT), 1'b1);
		st_chk(6'h0e, 1'b1);
		setp(pb(P_CORRUPT), 1'b0);
		st_chk(6'h0a, 1'b1);
		cnt_chk(2);
		setp(pb(P_HIGH), 1'b1);
		st_chk(6'h1a, 1'b1);
		cnt_chk(1);
		setp(pb(P_CHAN_A), 1'b1);
		setp(pb(P_CHAN_A), 1'b0);
		st_chk(6'h3a, 1'b1);
		cnt_chk(1);
		link_faulted <= 1'b1;
		@(posedge pclk);
		chk({31'h0, link_lost_copy}, 32'h1);
		n = 256 + $urandom_range(15, 0);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			want[P_CORRUPT] <= ~want[P_CORRUPT];
			want[P_DEMAND] <= 1'($urandom_range(1, 0));
			repeat ($urandom_range(2, 0)) @(posedge pclk);
		end
		repeat (8) @(posedge pclk);
		cnt_chk(n);
		apb(1'b1, OFF_CTRL, 32'h1);
		cnt_chk(1);
		apb(1'b1, OFF_CMD, 32'h2);
		exp_cnt = 8'h00;
		cnt_chk(0);
		setp(10'h3ff, 1'b0);
		do_reset();
		rd_chk(OFF_STATUS, 32'h0000000a, 32'h00001f8f);
		apb(1'b1, OFF_CTRL, 32'h0);
		setp(pb(P_SAFE) | pb(P_HIGH), 1'b1);
		rd_chk(OFF_STATUS, 32'h400, 32'hc00);
		end_sim();
	end
endmodule // test_safety_tap_diagnostic_status
